/* File: design/ccf_defs.vh */
// Constants for the comparator control and flag register block
`ifndef CCF_DEFS_VH
`define CCF_DEFS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define CCF_CTRL_ADDR    8'hf8
`define CCF_IRQ_STAT_ADDR 8'h00
`define CCF_IRQ_MASK_ADDR 8'h04

// ****************************************
// Control register fields
// ****************************************
`define CCF_BIT_ENABLE   7
`define CCF_BIT_OUTPUT   6
`define CCF_BIT_RISE     5
`define CCF_BIT_FALL     4
`define CCF_HYP_HI       3
`define CCF_HYP_LO       2
`define CCF_HYN_HI       1
`define CCF_HYN_LO       0

// ****************************************
// Reset values
// ****************************************
`define CCF_CTRL_RESET   8'h00
`define CCF_MASK_RESET   2'h0
`define CCF_STAT_RESET   2'h0

// ****************************************
// AXI responses
// ****************************************
`define CCF_RESP_OKAY    2'h0
`define CCF_RESP_SLVERR  2'h2

`endif

/* File: design/ccf_sync.v */
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/10ps

module ccf_sync (
   // Clock and reset
   input  wire CLK_SYS,
   input  wire RST_N,
   // Level in and out
   input  wire d_in,
   output wire q_out
);

   reg meta_reg;
   reg sync_reg;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign q_out = sync_reg;

endmodule // ccf_sync

/* File: design/ccf_edge.v */
// Edge detector on an already synchronised level
`timescale 1ns/10ps

module ccf_edge (
   // Clock and reset
   input  wire CLK_SYS,
   input  wire RST_N,
   // Level in, qualifier
   input  wire level_in,
   input  wire arm,
   // Edge pulses
   output wire rise_pulse,
   output wire fall_pulse
);

   reg prev_reg;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= level_in;
      end
   end

   // Edges only count while the comparator runs
   assign rise_pulse = arm & level_in & ~prev_reg;
   assign fall_pulse = arm & ~level_in & prev_reg;

endmodule // ccf_edge

/* File: design/ccf_top.v */
// Comparator control register, edge flags and AXI4-Lite slave
`timescale 1ns/10ps
`include "ccf_defs.vh"

module ccf_top #(
   parameter ADDR_W = 8
) (
   // Clock and reset
   input  wire              CLK_SYS,
   input  wire              RST_N,
   // AXI4-Lite write address
   input  wire [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire [2:0]        S_AXI_AWPROT,
   input  wire              S_AXI_AWVALID,
   output wire              S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire [31:0]       S_AXI_WDATA,
   input  wire [3:0]        S_AXI_WSTRB,
   input  wire              S_AXI_WVALID,
   output wire              S_AXI_WREADY,
   // AXI4-Lite write response
   output wire [1:0]        S_AXI_BRESP,
   output wire              S_AXI_BVALID,
   input  wire              S_AXI_BREADY,
   // AXI4-Lite read address
   input  wire [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire [2:0]        S_AXI_ARPROT,
   input  wire              S_AXI_ARVALID,
   output wire              S_AXI_ARREADY,
   // AXI4-Lite read data
   output wire [31:0]       S_AXI_RDATA,
   output wire [1:0]        S_AXI_RRESP,
   output wire              S_AXI_RVALID,
   input  wire              S_AXI_RREADY,
   // Analog comparator
   input  wire              CMP_RAW_OUT,
   output wire              CMP_ENABLE,
   output wire [1:0]        CMP_POS_HYST_SEL,
   output wire [1:0]        CMP_NEG_HYST_SEL,
   output wire              CMP_ROUTED_OUT,
   // Interrupt
   output wire              IRQ
);

   // ****************************************
   // Functions
   // ****************************************
   function addr_hit;
      input [ADDR_W-1:0] addr;
      input [7:0]        target;
      begin
         addr_hit = ({{(32-ADDR_W){1'b0}}, addr[ADDR_W-1:2], 2'b00} == {24'h000000, target});
      end
   endfunction

   function addr_known;
      input [ADDR_W-1:0] addr;
      begin
         addr_known = addr_hit(addr, `CCF_CTRL_ADDR) | addr_hit(addr, `CCF_IRQ_STAT_ADDR) |
                      addr_hit(addr, `CCF_IRQ_MASK_ADDR);
      end
   endfunction

   // ****************************************
   // Reset values of the control fields
   // ****************************************
   localparam [7:0] CTRL_RST     = `CCF_CTRL_RESET;
   localparam [0:0] ENABLE_RST   = CTRL_RST[`CCF_BIT_ENABLE];
   localparam [0:0] RISE_RST     = CTRL_RST[`CCF_BIT_RISE];
   localparam [0:0] FALL_RST     = CTRL_RST[`CCF_BIT_FALL];
   localparam [1:0] POS_HYST_RST = CTRL_RST[`CCF_HYP_HI:`CCF_HYP_LO];
   localparam [1:0] NEG_HYST_RST = CTRL_RST[`CCF_HYN_HI:`CCF_HYN_LO];

   // ****************************************
   // Registers
   // ****************************************
   reg              enable_reg;
   reg              rise_flag_reg;
   reg              fall_flag_reg;
   reg  [1:0]       pos_hyst_reg;
   reg  [1:0]       neg_hyst_reg;
   reg  [1:0]       irq_stat_reg;
   reg  [1:0]       irq_mask_reg;
   reg              aw_full_reg;
   reg  [ADDR_W-1:0] aw_addr_reg;
   reg              w_full_reg;
   reg  [31:0]      w_data_reg;
   reg  [3:0]       w_strb_reg;
   reg              bvalid_reg;
   reg  [1:0]       bresp_reg;
   reg              rvalid_reg;
   reg  [31:0]      rdata_reg;
   reg  [1:0]       rresp_reg;
   reg              enable_next;
   reg              rise_flag_next;
   reg              fall_flag_next;
   reg  [1:0]       pos_hyst_next;
   reg  [1:0]       neg_hyst_next;
   reg  [1:0]       irq_stat_next;

   wire             cmp_sync;
   wire             rise_pulse;
   wire             fall_pulse;
   wire             wr_fire;
   wire             rd_fire;
   wire             wr_ctrl;
   wire             wr_stat;
   wire             wr_mask;
   wire [7:0]       ctrl_view;

   // ****************************************
   // Comparator output path
   // ****************************************
   ccf_sync u_sync (
      .CLK_SYS (CLK_SYS),
      .RST_N   (RST_N),
      .d_in    (CMP_RAW_OUT),
      .q_out   (cmp_sync)
   );

   ccf_edge u_edge (
      .CLK_SYS    (CLK_SYS),
      .RST_N      (RST_N),
      .level_in   (cmp_sync),
      .arm        (enable_reg),
      .rise_pulse (rise_pulse),
      .fall_pulse (fall_pulse)
   );

   // ****************************************
   // Write channel capture
   // ****************************************
   // Readies drop while a response waits: one write in flight
   assign S_AXI_AWREADY = ~aw_full_reg & ~bvalid_reg;
   assign S_AXI_WREADY  = ~w_full_reg & ~bvalid_reg;
   assign wr_fire       = aw_full_reg & w_full_reg & ~bvalid_reg;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= {ADDR_W{1'b0}};
         w_full_reg  <= 1'b0;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `CCF_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_full_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end else if (wr_fire) begin
            w_full_reg <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= addr_known(aw_addr_reg) ? `CCF_RESP_OKAY : `CCF_RESP_SLVERR;
         end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Only byte lane 0 holds data
   assign wr_ctrl = wr_fire & w_strb_reg[0] & addr_hit(aw_addr_reg, `CCF_CTRL_ADDR);
   assign wr_stat = wr_fire & w_strb_reg[0] & addr_hit(aw_addr_reg, `CCF_IRQ_STAT_ADDR);
   assign wr_mask = wr_fire & w_strb_reg[0] & addr_hit(aw_addr_reg, `CCF_IRQ_MASK_ADDR);

   // ****************************************
   // Control register and edge flags
   // ****************************************
   always @* begin
      enable_next    = enable_reg;
      pos_hyst_next  = pos_hyst_reg;
      neg_hyst_next  = neg_hyst_reg;
      rise_flag_next = rise_flag_reg;
      fall_flag_next = fall_flag_reg;
      if (wr_ctrl) begin
         enable_next    = w_data_reg[`CCF_BIT_ENABLE];
         pos_hyst_next  = w_data_reg[`CCF_HYP_HI:`CCF_HYP_LO];
         neg_hyst_next  = w_data_reg[`CCF_HYN_HI:`CCF_HYN_LO];
         rise_flag_next = w_data_reg[`CCF_BIT_RISE];
         fall_flag_next = w_data_reg[`CCF_BIT_FALL];
      end
      // Edge wins over a same-cycle write
      if (rise_pulse) begin
         rise_flag_next = 1'b1;
      end
      if (fall_pulse) begin
         fall_flag_next = 1'b1;
      end
   end

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         enable_reg    <= ENABLE_RST;
         rise_flag_reg <= RISE_RST;
         fall_flag_reg <= FALL_RST;
         pos_hyst_reg  <= POS_HYST_RST;
         neg_hyst_reg  <= NEG_HYST_RST;
      end else begin
         enable_reg    <= enable_next;
         rise_flag_reg <= rise_flag_next;
         fall_flag_reg <= fall_flag_next;
         pos_hyst_reg  <= pos_hyst_next;
         neg_hyst_reg  <= neg_hyst_next;
      end
   end

   // ****************************************
   // Interrupt status and mask
   // ****************************************
   always @* begin
      irq_stat_next = irq_stat_reg;
      // Set beats write-one-clear
      if (wr_stat) begin
         irq_stat_next = irq_stat_reg & ~w_data_reg[1:0];
      end
      // Bit 1 rising, bit 0 falling
      if (rise_pulse) begin
         irq_stat_next[1] = 1'b1;
      end
      if (fall_pulse) begin
         irq_stat_next[0] = 1'b1;
      end
   end

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         irq_stat_reg <= `CCF_STAT_RESET;
         irq_mask_reg <= `CCF_MASK_RESET;
      end else begin
         irq_stat_reg <= irq_stat_next;
         if (wr_mask) begin
            irq_mask_reg <= w_data_reg[1:0];
         end
      end
   end

   assign IRQ = |(irq_stat_reg & irq_mask_reg);

   // ****************************************
   // Read channel
   // ****************************************
   assign ctrl_view = {enable_reg, cmp_sync & enable_reg, rise_flag_reg, fall_flag_reg,
                       pos_hyst_reg, neg_hyst_reg};
   assign S_AXI_ARREADY = ~rvalid_reg;
   assign rd_fire       = S_AXI_ARVALID & ~rvalid_reg;

   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= `CCF_RESP_OKAY;
      end else begin
         if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= addr_known(S_AXI_ARADDR) ? `CCF_RESP_OKAY : `CCF_RESP_SLVERR;
            if (addr_hit(S_AXI_ARADDR, `CCF_CTRL_ADDR)) begin
               rdata_reg <= {24'h000000, ctrl_view};
            end else if (addr_hit(S_AXI_ARADDR, `CCF_IRQ_STAT_ADDR)) begin
               rdata_reg <= {30'h00000000, irq_stat_reg};
            end else if (addr_hit(S_AXI_ARADDR, `CCF_IRQ_MASK_ADDR)) begin
               rdata_reg <= {30'h00000000, irq_mask_reg};
            end else begin
               rdata_reg <= 32'h00000000;
            end
         end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign S_AXI_BVALID     = bvalid_reg;
   assign S_AXI_BRESP      = bresp_reg;
   assign S_AXI_RVALID     = rvalid_reg;
   assign S_AXI_RDATA      = rdata_reg;
   assign S_AXI_RRESP      = rresp_reg;
   assign CMP_ENABLE       = enable_reg;
   assign CMP_POS_HYST_SEL = pos_hyst_reg;
   assign CMP_NEG_HYST_SEL = neg_hyst_reg;
   assign CMP_ROUTED_OUT   = cmp_sync & enable_reg;

endmodule // ccf_top

/* File: verif/ccf_assertions.sv */
// Port-level checks for the comparator control block
`timescale 1ns/10ps
module ccf_assertions (
   // Clock and reset
   input wire       CLK_SYS,
   input wire       RST_N,
   // Bus handshakes
   input wire       S_AXI_AWVALID,
   input wire       S_AXI_AWREADY,
   input wire       S_AXI_WVALID,
   input wire       S_AXI_WREADY,
   input wire       S_AXI_BVALID,
   input wire       S_AXI_ARVALID,
   input wire       S_AXI_ARREADY,
   input wire       S_AXI_RVALID,
   // Comparator side
   input wire       CMP_RAW_OUT,
   input wire       CMP_ENABLE,
   input wire [1:0] CMP_POS_HYST_SEL,
   input wire [1:0] CMP_NEG_HYST_SEL,
   input wire       CMP_ROUTED_OUT,
   input wire       IRQ
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   sequence s_wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_steady;
      (CMP_ENABLE && $stable(CMP_RAW_OUT))[*3];
   endsequence
   AST_ROUTED_LOW:
      assert property (!CMP_ENABLE |-> !CMP_ROUTED_OUT) else $error("routed high while off");
   AST_STEADY:
      assert property (s_steady |-> CMP_ROUTED_OUT == CMP_RAW_OUT) else $error("routed lags");
   AST_EN_WR:
      assert property ($changed(CMP_ENABLE) |-> S_AXI_BVALID) else $error("enable moved");
   AST_POS_WR:
      assert property ($changed(CMP_POS_HYST_SEL) |-> S_AXI_BVALID) else $error("pos moved");
   AST_NEG_WR:
      assert property ($changed(CMP_NEG_HYST_SEL) |-> S_AXI_BVALID) else $error("neg moved");
   AST_IRQ_RISE:
      assert property ($rose(IRQ) |-> S_AXI_BVALID || $past(CMP_ROUTED_OUT) != $past(CMP_ROUTED_OUT, 2))
         else $error("irq without cause");
   AST_READ_LAT:
      assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read late");
   AST_WRITE_LAT:
      assert property (s_wr_taken |-> ##2 S_AXI_BVALID) else $error("write late");
endmodule // ccf_assertions

bind ccf_top ccf_assertions ccf_assertions_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .CMP_RAW_OUT(CMP_RAW_OUT),
   .CMP_ENABLE(CMP_ENABLE), .CMP_POS_HYST_SEL(CMP_POS_HYST_SEL), .CMP_NEG_HYST_SEL(CMP_NEG_HYST_SEL),
   .CMP_ROUTED_OUT(CMP_ROUTED_OUT), .IRQ(IRQ));

/* File: verif/ccf_cmp_model.sv */
// Behavioural analog comparator with selectable hysteresis
`timescale 1ns/10ps
module ccf_cmp_model (
   // Trim selections
   input wire [1:0] pos_sel,
   input wire [1:0] neg_sel,
   // Input difference in mV
   input int        diff_mv,
   // Decision
   output logic     raw_out
);
   function automatic int sel_mv(input logic [1:0] s);
      return (s == 2'h0) ? 0 : 5 << (s - 2'h1);
   endfunction
   initial raw_out = 1'b0;
   // Decision flips only outside the band
   always @(diff_mv or pos_sel or neg_sel) begin
      if (diff_mv > sel_mv(pos_sel)) raw_out = 1'b1;
      else if (diff_mv < -sel_mv(neg_sel)) raw_out = 1'b0;
   end
endmodule // ccf_cmp_model

/* File: verif/test_comparator_control_flags.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
`include "ccf_defs.vh"
module test_comparator_control_flags;
   typedef struct {logic [7:0] wd; logic [7:0] rd;} ccf_row_t;
   logic        clk = 1'b0, rst_n = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, en, routed, irq, raw;
   wire [1:0]   bresp, rresp, pos, neg;
   wire [31:0]  rdata;
   int          diff_mv = -50, bad_count = 0, num_checks = 0;
   ccf_row_t    rows [5] = '{'{8'h85, 8'h85}, '{8'h0a, 8'h0a}, '{8'h8f, 8'h8f}, '{8'h70, 8'h30}, '{8'h00, 8'h00}};

   always #5 clk = ~clk;
   ccf_top ccf_top_i (.CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .CMP_RAW_OUT(raw), .CMP_ENABLE(en), .CMP_POS_HYST_SEL(pos),
      .CMP_NEG_HYST_SEL(neg), .CMP_ROUTED_OUT(routed), .IRQ(irq));
   ccf_cmp_model ccf_cmp_model_i (.pos_sel(pos), .neg_sel(neg), .diff_mv(diff_mv), .raw_out(raw));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      if (bvalid !== 1'b1) begin
         bad_count++;
         end_sim;
      end
      chk("bresp", bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      if (rvalid !== 1'b1) begin
         bad_count++;
         end_sim;
      end
      chk("rdata", rdata, ed);
      chk("rresp", rresp, er);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`CCF_CTRL_ADDR, 32'h0, `CCF_RESP_OKAY);
      chk("irq", irq, 32'h0);
      foreach (rows[i]) begin
         wr(`CCF_CTRL_ADDR, rows[i].wd, `CCF_RESP_OKAY);
         rd(`CCF_CTRL_ADDR, rows[i].rd, `CCF_RESP_OKAY);
         chk("enable", en, rows[i].rd[7]);
         chk("hyst", {pos, neg}, rows[i].rd[3:0]);
      end
      // Rising then falling edge while enabled
      wr(`CCF_IRQ_MASK_ADDR, 32'h3, `CCF_RESP_OKAY);
      wr(`CCF_CTRL_ADDR, 32'h80, `CCF_RESP_OKAY);
      diff_mv <= 50;
      repeat (4) @(posedge clk);
      rd(`CCF_CTRL_ADDR, 32'he0, `CCF_RESP_OKAY);
      chk("routed", routed, 32'h1);
      rd(`CCF_IRQ_STAT_ADDR, 32'h2, `CCF_RESP_OKAY);
      chk("irq", irq, 32'h1);
      wr(`CCF_CTRL_ADDR, 32'h80, `CCF_RESP_OKAY);
      wr(`CCF_IRQ_STAT_ADDR, 32'h2, `CCF_RESP_OKAY);
      rd(`CCF_CTRL_ADDR, 32'hc0, `CCF_RESP_OKAY);
      chk("irq", irq, 32'h0);
      diff_mv <= -50;
      repeat (4) @(posedge clk);
      rd(`CCF_CTRL_ADDR, 32'h90, `CCF_RESP_OKAY);
      rd(`CCF_IRQ_STAT_ADDR, 32'h1, `CCF_RESP_OKAY);
      wr(`CCF_IRQ_MASK_ADDR, 32'h0, `CCF_RESP_OKAY);
      chk("irq", irq, 32'h0);
      // Disabled: no events, output held low
      wr(`CCF_IRQ_STAT_ADDR, 32'h3, `CCF_RESP_OKAY);
      wr(`CCF_CTRL_ADDR, 32'h0, `CCF_RESP_OKAY);
      diff_mv <= 50;
      repeat (4) @(posedge clk);
      chk("routed", routed, 32'h0);
      rd(`CCF_CTRL_ADDR, 32'h0, `CCF_RESP_OKAY);
      rd(`CCF_IRQ_STAT_ADDR, 32'h0, `CCF_RESP_OKAY);
      wr(8'h08, 32'hff, `CCF_RESP_SLVERR);
      rd(8'h08, 32'h0, `CCF_RESP_SLVERR);
      // Edge in the same cycle as a clear: the edge wins
      wr(`CCF_CTRL_ADDR, 32'h80, `CCF_RESP_OKAY);
      diff_mv <= -50;
      wr(`CCF_CTRL_ADDR, 32'h80, `CCF_RESP_OKAY);
      diff_mv <= 50;
      wr(`CCF_IRQ_STAT_ADDR, 32'h2, `CCF_RESP_OKAY);
      // Byte lane 0 off: write ignored
      wstrb <= 4'h0;
      wr(`CCF_CTRL_ADDR, 32'h0, `CCF_RESP_OKAY);
      wstrb <= 4'hf;
      rd(`CCF_CTRL_ADDR, 32'hf0, `CCF_RESP_OKAY);
      rd(`CCF_IRQ_STAT_ADDR, 32'h3, `CCF_RESP_OKAY);
      // Reset in mid-run
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(`CCF_CTRL_ADDR, 32'h0, `CCF_RESP_OKAY);
      chk("enable", en, 32'h0);
      rd(`CCF_IRQ_STAT_ADDR, 32'h0, `CCF_RESP_OKAY);
      end_sim;
   end
endmodule // test_comparator_control_flags
